// File: pst_pkg.sv
// Package: constants and carrier types for the program space table access block
package pst_pkg;
    localparam int PM_AW = 24;
    localparam int PC_W = 23;
    localparam int DW = 16;
    localparam int PAGE_W = 8;
    // Register byte offsets on APB
    localparam logic [7:0] OFS_TABLE_PAGE = 8'h00;
    localparam logic [7:0] OFS_WINDOW_PAGE = 8'h04;
    localparam logic [7:0] OFS_CORE_CONTROL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam int CTL_WINDOW_EN_BIT = 2;
    localparam int STS_ADDR_LSB = 0;
    localparam int STS_BUSY_BIT = 24;
    localparam int STS_WINDOW_BIT = 25;
    localparam logic [7:0] TABLE_PAGE_RST = 8'h00;
    localparam logic [7:0] WINDOW_PAGE_RST = 8'h00;
    localparam int CFG_PAGE_BIT = 7;
    localparam int CFG_ADDR_BIT = 23;

    typedef enum logic [2:0] {
        PST_FETCH,
        PST_DATA_READ,
        PST_TABLE_READ_LOW,
        PST_TABLE_READ_HIGH,
        PST_TABLE_WRITE_LOW,
        PST_TABLE_WRITE_HIGH
    } pst_kind_t;

    typedef struct packed {
        pst_kind_t kind;
        logic byte_op;
        logic [PC_W-1:0] pc;
        logic [DW-1:0] effective_addr;
        logic [DW-1:0] wdata;
    } pst_req_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [PM_AW-1:0] addr;
        logic [PM_AW-1:0] wdata;
        logic [2:0] wmask;
    } pst_pm_cmd_t;

    typedef struct packed {
        pst_kind_t kind;
        logic byte_op;
        logic byte_sel;
        logic to_program;
    } pst_stage_t;
endpackage

// File: pst_table_access.sv
// Top module: program memory address builder, table read steering and APB registers
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
module pst_table_access
    import pst_pkg::*;
#(
    parameter int APB_AW = 8
)
(
    input wire logic clk_sys, // 20 MHz core clock
    input wire logic reset_n, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [APB_AW-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic req_valid, // Core request strobe
    input wire pst_req_t req, // Core request fields
    output pst_pm_cmd_t pm_cmd, // Program memory command
    input wire logic [PM_AW-1:0] pm_rdata, // Program word, one cycle after rd
    output logic rsp_valid, // Response strobe
    output logic [DW-1:0] rsp_data, // Steered data word
    output logic [PM_AW-1:0] rsp_instr, // Fetched instruction word
    output logic rsp_data_space // Data read left to data space
);
    // Four bits reach the status offset; wider buses decode the top bits as unmapped
    generate
        if (APB_AW < 4 || APB_AW > 32)
        begin
            $error("APB_AW must be 4 to 32");
        end
    endgenerate

    logic rst_meta_r;
    logic rst_n_r;
    logic [PAGE_W-1:0] table_page_r;
    logic [PAGE_W-1:0] window_page_r;
    logic window_en_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    pst_pm_cmd_t pm_cmd_r;
    pst_pm_cmd_t pm_cmd_nxt;
    pst_stage_t s1_r;
    pst_stage_t s2_r;
    logic s1_vld_r;
    logic s2_vld_r;
    logic rsp_valid_r;
    logic [DW-1:0] rsp_data_r;
    logic [PM_AW-1:0] rsp_instr_r;
    logic rsp_ds_r;
    logic table_busy;
    logic window_hit;
    logic is_table;
    logic is_write;
    logic [DW-1:0] steer;
    logic [31:0] rd_mux;
    logic rd_ok;
    logic [7:0] ofs;

    // Reset released through two flops
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // APB: one wait state so read data can come from a flop
    assign ofs = 8'(paddr);
    always_comb
    begin
        rd_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        if (ofs == OFS_TABLE_PAGE)
            rd_mux[PAGE_W-1:0] = table_page_r;
        else if (ofs == OFS_WINDOW_PAGE)
            rd_mux[PAGE_W-1:0] = window_page_r;
        else if (ofs == OFS_CORE_CONTROL)
            rd_mux[CTL_WINDOW_EN_BIT] = window_en_r;
        else if (ofs == OFS_STATUS)
        begin
            rd_mux[STS_ADDR_LSB +: PM_AW] = pm_cmd_r.addr;
            rd_mux[STS_BUSY_BIT] = table_busy;
            rd_mux[STS_WINDOW_BIT] = s1_vld_r && s1_r.to_program
                && s1_r.kind == PST_DATA_READ;
        end
        else
            rd_ok = 1'b0;
        if (APB_AW > 8 && (paddr >> 8) != '0)
            rd_ok = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            pready_r <= psel && penable && !pready_r;
            pslverr_r <= psel && penable && !pready_r && !rd_ok;
            if (psel && penable && !pready_r && !pwrite && rd_ok)
                prdata_r <= rd_mux;
            else
                prdata_r <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            table_page_r <= TABLE_PAGE_RST;
            window_page_r <= WINDOW_PAGE_RST;
            window_en_r <= 1'b0;
        end
        else if (psel && penable && pready_r && pwrite && !pslverr_r)
        begin
            if (ofs == OFS_TABLE_PAGE)
                table_page_r <= pwdata[PAGE_W-1:0];
            else if (ofs == OFS_WINDOW_PAGE)
                window_page_r <= pwdata[PAGE_W-1:0];
            else if (ofs == OFS_CORE_CONTROL)
                window_en_r <= pwdata[CTL_WINDOW_EN_BIT];
        end
    end

    // Address construction
    assign is_table = req.kind inside {PST_TABLE_READ_LOW, PST_TABLE_READ_HIGH,
        PST_TABLE_WRITE_LOW, PST_TABLE_WRITE_HIGH};
    assign is_write = req.kind inside {PST_TABLE_WRITE_LOW, PST_TABLE_WRITE_HIGH};
    // A table op still in flight holds the window shut
    assign table_busy = (s1_vld_r && s1_r.kind != PST_FETCH && s1_r.kind != PST_DATA_READ)
        || (s2_vld_r && s2_r.kind != PST_FETCH && s2_r.kind != PST_DATA_READ);
    assign window_hit = req.kind == PST_DATA_READ && req.effective_addr[DW-1]
        && window_en_r && !table_busy;

    always_comb
    begin
        pm_cmd_nxt = '0;
        if (req_valid)
        begin
            if (req.kind == PST_FETCH)
            begin
                pm_cmd_nxt.rd = 1'b1;
                // Bit 0 dropped: words step by two, bit 23 forced clear
                pm_cmd_nxt.addr = {1'b0, req.pc[PC_W-1:1], 1'b0};
            end
            else if (is_table)
            begin
                pm_cmd_nxt.rd = !is_write;
                pm_cmd_nxt.wr = is_write;
                // Page bit 7 lands on address bit 23: configuration space
                pm_cmd_nxt.addr = {table_page_r, req.effective_addr[DW-1:1],
                    1'b0};
            end
            else if (window_hit)
            begin
                pm_cmd_nxt.rd = 1'b1;
                pm_cmd_nxt.addr = {1'b0, window_page_r, req.effective_addr[DW-2:1],
                    1'b0};
            end
            if (req.kind == PST_TABLE_WRITE_LOW)
            begin
                if (!req.byte_op)
                begin
                    pm_cmd_nxt.wdata[DW-1:0] = req.wdata;
                    pm_cmd_nxt.wmask = 3'b011;
                end
                else if (req.effective_addr[0])
                begin
                    pm_cmd_nxt.wdata[15:8] = req.wdata[7:0];
                    pm_cmd_nxt.wmask = 3'b010;
                end
                else
                begin
                    pm_cmd_nxt.wdata[7:0] = req.wdata[7:0];
                    pm_cmd_nxt.wmask = 3'b001;
                end
            end
            else if (req.kind == PST_TABLE_WRITE_HIGH)
            begin
                // Upper byte is writable only here; high byte 1 does nothing
                pm_cmd_nxt.wdata[23:16] = req.wdata[7:0];
                pm_cmd_nxt.wmask = (req.byte_op && req.effective_addr[0])
                    ? 3'b000 : 3'b100;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
            pm_cmd_r <= '0;
        else
            pm_cmd_r <= pm_cmd_nxt;
    end

    // Request pipeline: memory answers one cycle after rd
    always_ff @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            s1_vld_r <= 1'b0;
            s2_vld_r <= 1'b0;
            s1_r <= '0;
            s2_r <= '0;
        end
        else
        begin
            s1_vld_r <= req_valid;
            s1_r.kind <= req.kind;
            s1_r.byte_op <= req.byte_op;
            s1_r.byte_sel <= req.effective_addr[0];
            s1_r.to_program <= req.kind != PST_DATA_READ || window_hit;
            s2_vld_r <= s1_vld_r;
            s2_r <= s1_r;
        end
    end

    // Read data steering onto the 16-bit data path
    always_comb
    begin
        steer = '0;
        if (s2_r.kind == PST_TABLE_READ_HIGH)
        begin
            if (!s2_r.byte_sel || !s2_r.byte_op)
                steer[7:0] = pm_rdata[23:16];
        end
        else if (!s2_r.byte_op)
            steer = pm_rdata[DW-1:0];
        else if (s2_r.byte_sel)
            steer[7:0] = pm_rdata[15:8];
        else
            steer[7:0] = pm_rdata[7:0];
    end

    always_ff @(posedge clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            rsp_valid_r <= 1'b0;
            rsp_data_r <= '0;
            rsp_instr_r <= '0;
            rsp_ds_r <= 1'b0;
        end
        else
        begin
            rsp_valid_r <= s2_vld_r;
            rsp_ds_r <= s2_vld_r && !s2_r.to_program;
            rsp_data_r <= '0;
            if (s2_vld_r && s2_r.kind == PST_FETCH)
                rsp_instr_r <= pm_rdata;
            if (s2_vld_r && s2_r.to_program && s2_r.kind != PST_FETCH
                && s2_r.kind != PST_TABLE_WRITE_LOW && s2_r.kind != PST_TABLE_WRITE_HIGH)
                rsp_data_r <= steer;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pm_cmd = pm_cmd_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_data = rsp_data_r;
    assign rsp_instr = rsp_instr_r;
    assign rsp_data_space = rsp_ds_r;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n_r);

    sequence s_fetch_req;
        req_valid && req.kind == PST_FETCH;
    endsequence
    sequence s_table_cfg_req;
        req_valid && is_table && table_page_r[CFG_PAGE_BIT];
    endsequence

    property p_fetch_addr;
        s_fetch_req |=> pm_cmd.rd && pm_cmd.addr == {1'b0, $past(req.pc[PC_W-1:1]), 1'b0};
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address wrong");
    property p_bit23;
        (pm_cmd.rd || pm_cmd.wr) && pm_cmd.addr[CFG_ADDR_BIT]
            |-> $past(table_page_r[CFG_PAGE_BIT]) && $past(is_table);
    endproperty
    a_bit23: assert property (p_bit23) else $error("bit 23 set outside config table");
    property p_table_addr;
        s_table_cfg_req |=> pm_cmd.addr[CFG_ADDR_BIT];
    endproperty
    a_table_addr: assert property (p_table_addr)
        else $error("config table lost bit 23");
    property p_window_addr;
        req_valid && req.kind == PST_DATA_READ && req.effective_addr[DW-1] && window_en_r
            && !table_busy |=> pm_cmd.rd && pm_cmd.addr[22:15] == $past(window_page_r);
    endproperty
    a_window_addr: assert property (p_window_addr) else $error("window page not used");
    property p_window_gate;
        req_valid && req.kind == PST_DATA_READ && (!window_en_r || !req.effective_addr[DW-1])
            |=> !pm_cmd.rd ##2 rsp_data_space;
    endproperty
    a_window_gate: assert property (p_window_gate) else $error("window opened wrongly");
    property p_window_suspend;
        req_valid && req.kind == PST_DATA_READ && table_busy |=> !pm_cmd.rd;
    endproperty
    a_window_suspend: assert property (p_window_suspend)
        else $error("window open in table op");
    property p_high_word;
        s2_vld_r && s2_r.kind == PST_TABLE_READ_HIGH && !s2_r.byte_op
            |=> rsp_valid && rsp_data == {8'h00, $past(pm_rdata[23:16])};
    endproperty
    a_high_word: assert property (p_high_word) else $error("high word read wrong");
    property p_low_byte;
        s2_vld_r && s2_r.kind == PST_TABLE_READ_LOW && s2_r.byte_op && s2_r.byte_sel
            |=> rsp_data == {8'h00, $past(pm_rdata[15:8])};
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte select wrong");
    property p_latency;
        req_valid |-> ##3 rsp_valid;
    endproperty
    a_latency: assert property (p_latency) else $error("response not at cycle 3");
endmodule

// File: pst_pm_model.sv
// Program memory model facing the block's program memory command port
`timescale 1ns/100ps
module pst_pm_model
    import pst_pkg::*;
(
    clk_sys, // Core clock
    pm_cmd, // Command from the block
    pm_rdata // Program word back to the block
);
    input wire logic clk_sys;
    input wire pst_pm_cmd_t pm_cmd;
    output logic [PM_AW-1:0] pm_rdata;

    // Content derived from the address so every word is distinct
    function automatic logic [PM_AW-1:0] word_at(input logic [PM_AW-1:0] a);
        return {a[23:16] ^ a[8:1], a[15:0] ^ 16'hC3A5};
    endfunction

    initial pm_rdata = 24'h00_0000;

    // Valid in the cycle after a read; inverted each idle cycle, so stale data matches again every second cycle
    always @(posedge clk_sys)
    begin
        if (pm_cmd.rd)
            pm_rdata <= word_at(pm_cmd.addr);
        else
            pm_rdata <= ~pm_rdata;
    end
endmodule

// File: program_space_table_access_tb_top.sv
// Testbench: core requests and APB traffic, checks program addresses and steered data
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module program_space_table_access_tb_top;
    import pst_pkg::*;
    typedef struct packed {logic rd; logic wr; logic [23:0] addr; logic [2:0] wmask;
        logic [23:0] wdata; logic [23:0] lanes;} pst_cexp_t;
    typedef struct packed {logic [15:0] data; logic space; logic fetch; logic [23:0] instr;} pst_rexp_t;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic req_valid = 1'b0;
    pst_req_t req = '0;
    pst_pm_cmd_t pm_cmd;
    logic [PM_AW-1:0] pm_rdata;
    logic rsp_valid;
    logic [DW-1:0] rsp_data;
    logic [PM_AW-1:0] rsp_instr;
    logic rsp_data_space;
    int n_fail = 0;
    int total_checks = 0;
    int slot = 0;
    int tbl_slot = -100;
    logic [7:0] tpage = 8'h00;
    logic [7:0] wpage = 8'h00;
    logic win_en = 1'b0;
    logic [15:0] rnd = 16'h0045;
    pst_cexp_t cq[$];
    pst_rexp_t rq[$];
    pst_cexp_t ce;
    pst_rexp_t re;

    pst_table_access #(.APB_AW(8)) uut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req(req), .pm_cmd(pm_cmd),
        .pm_rdata(pm_rdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_instr(rsp_instr), .rsp_data_space(rsp_data_space));
    pst_pm_model u_mem (.clk_sys(clk_sys), .pm_cmd(pm_cmd), .pm_rdata(pm_rdata));

    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic finish_test();
        if (cq.size() != 0 || rq.size() != 0)
            n_fail++;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
        input logic [31:0] ed, input logic ee);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Request stands until the edge at which pready is sampled high
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_sys);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            n_fail++;
            finish_test();
        end
        `CHK("pslverr", ee, pslverr)
        if (!wr)
            `CHK("prdata", ed, prdata)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            req_valid <= 1'b0;
            slot++;
        end
    endtask

    task automatic send(input pst_kind_t k, input logic bop, input logic [22:0] pc,
        input logic [15:0] eaddr, input logic [15:0] wd);
        logic [23:0] a;
        logic [23:0] p;
        logic tbl;
        logic win;
        pst_cexp_t c;
        pst_rexp_t r;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= pst_req_t'({k, bop, pc, eaddr, wd});
        slot++;
        tbl = k inside {PST_TABLE_READ_LOW, PST_TABLE_READ_HIGH, PST_TABLE_WRITE_LOW,
            PST_TABLE_WRITE_HIGH};
        win = k == PST_DATA_READ && eaddr[15] && win_en && slot - tbl_slot > 2;
        a = k == PST_FETCH ? {1'b0, pc[22:1], 1'b0} : tbl ? {tpage, eaddr[15:1], 1'b0}
            : {1'b0, wpage, eaddr[14:1], 1'b0};
        p = u_mem.word_at(a);
        c = '0;
        r = '0;
        c.addr = a;
        c.rd = k inside {PST_FETCH, PST_TABLE_READ_LOW, PST_TABLE_READ_HIGH} || win;
        c.wr = k inside {PST_TABLE_WRITE_LOW, PST_TABLE_WRITE_HIGH};
        c.wdata = {wd[7:0], bop ? {wd[7:0], wd[7:0]} : wd};
        // High byte write with select one touches no lane
        c.wmask = k != PST_TABLE_WRITE_HIGH ? (!bop ? 3'b011 : eaddr[0] ? 3'b010 : 3'b001)
            : (bop && eaddr[0]) ? 3'b000 : 3'b100;
        c.lanes = {{8{c.wmask[2]}}, {8{c.wmask[1]}}, {8{c.wmask[0]}}};
        r.space = k == PST_DATA_READ && !win;
        r.fetch = k == PST_FETCH;
        r.instr = p;
        if (k == PST_TABLE_READ_LOW)
            r.data = bop ? {8'h00, eaddr[0] ? p[15:8] : p[7:0]} : p[15:0];
        else if (k == PST_TABLE_READ_HIGH)
            r.data = {8'h00, (bop && eaddr[0]) ? 8'h00 : p[23:16]};
        else if (win)
            r.data = p[15:0];
        if (c.rd || c.wr)
            cq.push_back(c);
        rq.push_back(r);
        if (tbl)
            tbl_slot = slot;
    endtask

    always @(negedge clk_sys)
    begin
        if (pm_cmd.rd === 1'b1 || pm_cmd.wr === 1'b1)
        begin
            if (cq.size() == 0)
                `CHK("pm_cmd_count", 1'b0, 1'b1)
            else
            begin
                ce = cq.pop_front();
                `CHK("pm_rd", ce.rd, pm_cmd.rd)
                `CHK("pm_wr", ce.wr, pm_cmd.wr)
                `CHK("pm_addr_top", ce.addr[23], pm_cmd.addr[23])
                `CHK("pm_addr_mid", ce.addr[22:15], pm_cmd.addr[22:15])
                `CHK("pm_addr_low", ce.addr[14:0], pm_cmd.addr[14:0])
                if (ce.wr)
                    `CHK("pm_wmask", ce.wmask, pm_cmd.wmask)
                if (ce.wr)
                    `CHK("pm_wdata", ce.wdata & ce.lanes, pm_cmd.wdata & ce.lanes)
            end
        end
        if (rsp_valid === 1'b1)
        begin
            if (rq.size() == 0)
                `CHK("rsp_count", 1'b0, 1'b1)
            else
            begin
                re = rq.pop_front();
                `CHK("rsp_data", re.data, rsp_data)
                `CHK("rsp_space", re.space, rsp_data_space)
                if (re.fetch)
                    `CHK("rsp_instr", re.instr, rsp_instr)
            end
        end
    end

    initial
    begin
        #2_000_000;
        n_fail++;
        finish_test();
    end

    initial
    begin
        int i;
        int pg;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        apb(0, OFS_TABLE_PAGE, 0, {24'h00_0000, TABLE_PAGE_RST}, 0);
        apb(0, OFS_WINDOW_PAGE, 0, {24'h00_0000, WINDOW_PAGE_RST}, 0);
        apb(0, OFS_CORE_CONTROL, 0, 0, 0);
        apb(1, 8'h10, 32'hFFFF_FFFF, 0, 1);
        apb(0, 8'h10, 0, 0, 1);
        $display("test registers done");
        for (i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            send(PST_FETCH, 1'b0, {rnd[6:0], rnd}, 16'h0000, 16'h0000);
        end
        send(PST_FETCH, 1'b0, 23'h7F_FFFF, 16'h0000, 16'h0000);
        idle(4);
        $display("test fetch done");
        for (pg = 0; pg < 3; pg++)
        begin
            rnd = lfsr(rnd);
            tpage = pg == 0 ? 8'h00 : pg == 1 ? 8'h80 : rnd[7:0];
            apb(1, OFS_TABLE_PAGE, {24'h00_0000, tpage}, 0, 0);
            apb(0, OFS_TABLE_PAGE, 0, {24'h00_0000, tpage}, 0);
            for (i = 0; i < 16; i++)
            begin
                rnd = lfsr(rnd);
                send(i[3] ? (i[2] ? PST_TABLE_WRITE_HIGH : PST_TABLE_WRITE_LOW)
                    : (i[2] ? PST_TABLE_READ_HIGH : PST_TABLE_READ_LOW),
                    i[1], 23'h00_0000, {rnd[15:1], i[0]}, lfsr(rnd));
            end
            idle(4);
        end
        $display("test table done");
        rnd = lfsr(rnd);
        wpage = rnd[7:0];
        win_en = 1'b1;
        apb(1, OFS_WINDOW_PAGE, {24'h00_0000, wpage}, 0, 0);
        apb(1, OFS_CORE_CONTROL, 32'h0000_0004, 0, 0);
        apb(0, OFS_WINDOW_PAGE, 0, {24'h00_0000, wpage}, 0);
        apb(0, OFS_CORE_CONTROL, 0, 32'h0000_0004, 0);
        send(PST_DATA_READ, 1'b0, 23'h00_0000, 16'h8000 | rnd, 16'h0000);
        send(PST_DATA_READ, 1'b0, 23'h00_0000, 16'h7FFF & rnd, 16'h0000);
        send(PST_TABLE_READ_LOW, 1'b0, 23'h00_0000, rnd, 16'h0000);
        send(PST_DATA_READ, 1'b0, 23'h00_0000, 16'hFFFE, 16'h0000);
        send(PST_DATA_READ, 1'b0, 23'h00_0000, 16'hC002, 16'h0000);
        send(PST_DATA_READ, 1'b0, 23'h00_0000, 16'h8004, 16'h0000);
        idle(4);
        win_en = 1'b0;
        apb(1, OFS_CORE_CONTROL, 32'h0000_0000, 0, 0);
        send(PST_DATA_READ, 1'b0, 23'h00_0000, 16'h9000, 16'h0000);
        idle(6);
        $display("test window done");
        finish_test();
    end
endmodule
